// ===== common/slwf_pkg.sv
// constants and carrier types shared by the servo limit and warning flag block
package slwf_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 200;
    localparam int BRK_UNIT_MS = 10; // brake delay settings count in 10 ms steps
    localparam int BRK_TICK_CYCLES = BRK_UNIT_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // thresholds
    localparam logic [15:0] WARN_TORQUE_PCT = 16'h0073; // 115 percent of rated
    localparam logic [15:0] REGEN_INT_TOL = 16'h1000;
    localparam logic [3:0] SEL_OPT1 = 4'h1;
    localparam logic [3:0] SEL_OPT12 = 4'h3;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FWD_TQ = 8'h04;
    localparam logic [7:0] REG_REV_TQ = 8'h08;
    localparam logic [7:0] REG_FWD_EXT = 8'h0c;
    localparam logic [7:0] REG_REV_EXT = 8'h10;
    localparam logic [7:0] REG_SPD_LIM = 8'h14;
    localparam logic [7:0] REG_BRK_D1 = 8'h18;
    localparam logic [7:0] REG_BRK_SPD = 8'h1c;
    localparam logic [7:0] REG_BRK_D2 = 8'h20;
    localparam logic [7:0] REG_REGEN_CAP = 8'h24;
    localparam logic [7:0] REG_ALLOC = 8'h28;
    localparam logic [7:0] REG_FLAGS = 8'h2c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h30;
    localparam logic [7:0] REG_IRQ_MASK = 8'h34;

    // ==========================================================
    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TQ_SEL_LSB = 4;
    localparam int CTRL_SPD_SEL_LSB = 8;
    localparam int ALLOC_CUR_LSB = 0;
    localparam int ALLOC_SPD_LSB = 4;
    localparam int ALLOC_BRK_LSB = 8;
    localparam int ALLOC_WARN_LSB = 12;
    localparam int SEQ_PINS = 3;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_TQ_LIM = 16'h015e;
    localparam logic [15:0] RST_EXT_LIM = 16'h0064;
    localparam logic [15:0] RST_SPD_LIM = 16'h2710;
    localparam logic [15:0] RST_BRK_D1 = 16'h0000;
    localparam logic [15:0] RST_BRK_SPD = 16'h0064;
    localparam logic [15:0] RST_BRK_D2 = 16'h0032;
    localparam logic [15:0] RST_REGEN_CAP = 16'h0000;
    localparam logic [15:0] RST_ALLOC = 16'h0100; // only the brake goes to pin 1

    // ==========================================================
    // types
    typedef enum logic [1:0] {MODE_POSITION, MODE_SPEED, MODE_TORQUE} slwf_mode_t;
    typedef enum logic [1:0] {BRK_ENGAGED, BRK_RELEASED, BRK_STOP_WAIT, BRK_RUN_WAIT} slwf_brk_t;

    typedef struct packed {
        logic signed [15:0] torque; // percent of rated, sign gives direction
        logic signed [15:0] speed; // r/min, sign gives direction
        logic [15:0] eff_torque; // effective torque, percent of rated
        logic [15:0] regen_energy;
        logic servo_on;
    } slwf_mon_t;

    typedef struct packed {
        logic ext_limit_on;
        logic [15:0] opt_val1;
        logic [15:0] opt_val2;
    } slwf_host_t;

    typedef struct packed {
        logic warn;
        logic brake;
        logic speed;
        logic current;
    } slwf_flags_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] fwd_tq;
        logic [15:0] rev_tq;
        logic [15:0] fwd_ext;
        logic [15:0] rev_ext;
        logic [15:0] spd_lim;
        logic [15:0] brk_d1;
        logic [15:0] brk_spd;
        logic [15:0] brk_d2;
        logic [15:0] regen_cap;
        logic [15:0] alloc;
    } slwf_cfg_t;

endpackage

// ===== rtl/slwf_reach.sv
// two-sided limit comparator: signed value against forward and reverse magnitudes
module slwf_reach (
    // control
    input wire logic en_i,
    // operands
    input wire logic signed [15:0] value_i,
    input wire logic [15:0] fwd_lim_i,
    input wire logic [15:0] rev_lim_i,
    // result
    output logic reach_o
);
    logic signed [16:0] wide;
    logic signed [16:0] neg;

    // widen first so that the most negative value still negates cleanly
    always_comb begin
        wide = {value_i[15], value_i};
        neg = 17'sh0 - wide;
        reach_o = en_i && ((wide >= $signed({1'b0, fwd_lim_i}))
                        || (neg >= $signed({1'b0, rev_lim_i})));
    end
endmodule

// ===== rtl/slwf_top.sv
// servo limit and warning flags with allocation, brake timing and wishbone registers
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
module slwf_top #(
    parameter int TICK_CYCLES = slwf_pkg::BRK_TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // drive monitors and host commands
    input wire slwf_pkg::slwf_mon_t mon_i,
    input wire slwf_pkg::slwf_host_t host_i,
    // sequence outputs
    output logic [2:0] seq_out_o,
    output slwf_pkg::slwf_flags_t flags_o,
    output logic irq_o
);

    // ==========================================================
    // register state
    slwf_pkg::slwf_cfg_t cfg, next_cfg;
    slwf_pkg::slwf_flags_t irq_stat, next_irq_stat;
    slwf_pkg::slwf_flags_t irq_mask, next_irq_mask;
    slwf_pkg::slwf_flags_t flags, next_flags;
    logic [31:0] next_dat;
    logic next_ack;
    logic next_irq;
    logic [2:0] next_seq;
    logic wr_hit;
    logic [15:0] wval;
    logic [15:0] rval;

    // ==========================================================
    // condition sources
    logic [3:0] tq_sel;
    logic [3:0] spd_sel;
    logic torque_mode;
    logic cur_int, cur_ext, cur_opt1, cur_opt12, spd_set, spd_opt;
    logic cur_any, spd_any, warn_any;
    logic [15:0] spd_mag;

    always_comb begin
        tq_sel = cfg.ctrl[slwf_pkg::CTRL_TQ_SEL_LSB +: 4];
        spd_sel = cfg.ctrl[slwf_pkg::CTRL_SPD_SEL_LSB +: 4];
        torque_mode = slwf_pkg::slwf_mode_t'(cfg.ctrl[slwf_pkg::CTRL_MODE_LSB +: 2])
                      == slwf_pkg::MODE_TORQUE;
        spd_mag = mon_i.speed[15] ? 16'h0000 - mon_i.speed : mon_i.speed;
    end

    slwf_reach u_cur_int (
        .en_i(1'b1),
        .value_i(mon_i.torque),
        .fwd_lim_i(cfg.fwd_tq),
        .rev_lim_i(cfg.rev_tq),
        .reach_o(cur_int)
    );

    slwf_reach u_cur_ext (
        .en_i(host_i.ext_limit_on),
        .value_i(mon_i.torque),
        .fwd_lim_i(cfg.fwd_ext),
        .rev_lim_i(cfg.rev_ext),
        .reach_o(cur_ext)
    );

    slwf_reach u_cur_opt1 (
        .en_i(tq_sel == slwf_pkg::SEL_OPT1),
        .value_i(mon_i.torque),
        .fwd_lim_i(host_i.opt_val1),
        .rev_lim_i(host_i.opt_val1),
        .reach_o(cur_opt1)
    );

    // value 1 limits forward torque and value 2 limits reverse torque
    slwf_reach u_cur_opt12 (
        .en_i(tq_sel == slwf_pkg::SEL_OPT12 && host_i.ext_limit_on),
        .value_i(mon_i.torque),
        .fwd_lim_i(host_i.opt_val1),
        .rev_lim_i(host_i.opt_val2),
        .reach_o(cur_opt12)
    );

    slwf_reach u_spd_set (
        .en_i(torque_mode),
        .value_i(mon_i.speed),
        .fwd_lim_i(cfg.spd_lim),
        .rev_lim_i(cfg.spd_lim),
        .reach_o(spd_set)
    );

    slwf_reach u_spd_opt (
        .en_i(torque_mode && spd_sel == slwf_pkg::SEL_OPT1),
        .value_i(mon_i.speed),
        .fwd_lim_i(host_i.opt_val1),
        .rev_lim_i(host_i.opt_val1),
        .reach_o(spd_opt)
    );

    // plain OR of conditions, nothing held once they all clear
    always_comb begin
        cur_any = cur_int | cur_ext | cur_opt1 | cur_opt12;
        spd_any = torque_mode & (spd_set | spd_opt);
        warn_any = (mon_i.eff_torque > slwf_pkg::WARN_TORQUE_PCT)
                 | (mon_i.regen_energy > slwf_pkg::REGEN_INT_TOL)
                 | (cfg.regen_cap != 16'h0000 && mon_i.regen_energy > cfg.regen_cap);
    end

    // ==========================================================
    // brake interlock timing
    slwf_pkg::slwf_brk_t brk, next_brk;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [15:0] dly_cnt, next_dly_cnt;
    logic tick;

    // one delay unit is a long run of clocks, so a prescaler feeds a short counter
    always_comb begin
        tick = tick_cnt == 32'(TICK_CYCLES - 1);
        next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        next_brk = brk;
        next_dly_cnt = dly_cnt;
        case (brk)
            slwf_pkg::BRK_ENGAGED: begin
                if (mon_i.servo_on) begin
                    next_brk = slwf_pkg::BRK_RELEASED;
                end
            end
            slwf_pkg::BRK_RELEASED: begin
                next_dly_cnt = 16'h0000;
                if (!mon_i.servo_on) begin
                    next_brk = (spd_mag < cfg.brk_spd) ? slwf_pkg::BRK_STOP_WAIT
                                                       : slwf_pkg::BRK_RUN_WAIT;
                end
            end
            slwf_pkg::BRK_STOP_WAIT: begin
                if (mon_i.servo_on) begin
                    next_brk = slwf_pkg::BRK_RELEASED;
                end else if (dly_cnt >= cfg.brk_d1) begin
                    next_brk = slwf_pkg::BRK_ENGAGED;
                end else if (tick) begin
                    next_dly_cnt = dly_cnt + 16'h0001;
                end
            end
            slwf_pkg::BRK_RUN_WAIT: begin
                // a coasting motor gets the brake once slow, or after the second delay
                if (mon_i.servo_on) begin
                    next_brk = slwf_pkg::BRK_RELEASED;
                end else if (spd_mag < cfg.brk_spd || dly_cnt >= cfg.brk_d2) begin
                    next_brk = slwf_pkg::BRK_ENGAGED;
                end else if (tick) begin
                    next_dly_cnt = dly_cnt + 16'h0001;
                end
            end
            default: begin
                next_brk = slwf_pkg::BRK_ENGAGED;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brk <= slwf_pkg::BRK_ENGAGED;
            tick_cnt <= 32'h0000_0000;
            dly_cnt <= 16'h0000;
        end else if (ce_i) begin
            brk <= next_brk;
            tick_cnt <= next_tick_cnt;
            dly_cnt <= next_dly_cnt;
        end
    end

    // ==========================================================
    // flags, output allocation, interrupt
    function automatic logic [2:0] route(input logic [3:0] pin, input logic on);
        logic [2:0] r;
        r = 3'h0;
        if (on && pin != 4'h0 && pin <= 4'(slwf_pkg::SEQ_PINS)) begin
            r[2'(pin - 4'h1)] = 1'b1;
        end
        return r;
    endfunction

    always_comb begin
        next_flags.current = cur_any;
        next_flags.speed = spd_any;
        next_flags.warn = warn_any;
        next_flags.brake = (next_brk != slwf_pkg::BRK_ENGAGED);
        // each flag reaches a pin only through its own nibble
        next_seq = route(cfg.alloc[slwf_pkg::ALLOC_CUR_LSB +: 4], flags.current)
                 | route(cfg.alloc[slwf_pkg::ALLOC_SPD_LSB +: 4], flags.speed)
                 | route(cfg.alloc[slwf_pkg::ALLOC_BRK_LSB +: 4], flags.brake)
                 | route(cfg.alloc[slwf_pkg::ALLOC_WARN_LSB +: 4], flags.warn);
    end

    // ==========================================================
    // wishbone register file
    always_comb begin
        wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
        wval = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
        next_cfg = cfg;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr_hit) begin
            case (wb_adr_i)
                slwf_pkg::REG_CTRL: next_cfg.ctrl = wval;
                slwf_pkg::REG_FWD_TQ: next_cfg.fwd_tq = wval;
                slwf_pkg::REG_REV_TQ: next_cfg.rev_tq = wval;
                slwf_pkg::REG_FWD_EXT: next_cfg.fwd_ext = wval;
                slwf_pkg::REG_REV_EXT: next_cfg.rev_ext = wval;
                slwf_pkg::REG_SPD_LIM: next_cfg.spd_lim = wval;
                slwf_pkg::REG_BRK_D1: next_cfg.brk_d1 = wval;
                slwf_pkg::REG_BRK_SPD: next_cfg.brk_spd = wval;
                slwf_pkg::REG_BRK_D2: next_cfg.brk_d2 = wval;
                slwf_pkg::REG_REGEN_CAP: next_cfg.regen_cap = wval;
                slwf_pkg::REG_ALLOC: next_cfg.alloc = wval;
                slwf_pkg::REG_IRQ_MASK: next_irq_mask = wval[3:0];
                slwf_pkg::REG_IRQ_STAT: next_irq_stat = irq_stat & ~wval[3:0];
                default: next_cfg = cfg;
            endcase
        end
        // rising flags set their bits after the clear, so a same-cycle event survives
        next_irq_stat = next_irq_stat | (next_flags & ~flags);
        next_irq = |(next_irq_stat & next_irq_mask);
        case (wb_adr_i)
            slwf_pkg::REG_CTRL: rval = cfg.ctrl;
            slwf_pkg::REG_FWD_TQ: rval = cfg.fwd_tq;
            slwf_pkg::REG_REV_TQ: rval = cfg.rev_tq;
            slwf_pkg::REG_FWD_EXT: rval = cfg.fwd_ext;
            slwf_pkg::REG_REV_EXT: rval = cfg.rev_ext;
            slwf_pkg::REG_SPD_LIM: rval = cfg.spd_lim;
            slwf_pkg::REG_BRK_D1: rval = cfg.brk_d1;
            slwf_pkg::REG_BRK_SPD: rval = cfg.brk_spd;
            slwf_pkg::REG_BRK_D2: rval = cfg.brk_d2;
            slwf_pkg::REG_REGEN_CAP: rval = cfg.regen_cap;
            slwf_pkg::REG_ALLOC: rval = cfg.alloc;
            slwf_pkg::REG_FLAGS: rval = {12'h000, flags};
            slwf_pkg::REG_IRQ_STAT: rval = {12'h000, irq_stat};
            slwf_pkg::REG_IRQ_MASK: rval = {12'h000, irq_mask};
            default: rval = 16'h0000; // unmapped reads zero and still acks
        endcase
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = next_ack ? {16'h0000, rval} : 32'h0000_0000;
    end

    // the bus keeps answering while ce_i is low; register writes are dropped and all other state freezes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= '{slwf_pkg::RST_CTRL, slwf_pkg::RST_TQ_LIM, slwf_pkg::RST_TQ_LIM,
                     slwf_pkg::RST_EXT_LIM, slwf_pkg::RST_EXT_LIM, slwf_pkg::RST_SPD_LIM,
                     slwf_pkg::RST_BRK_D1, slwf_pkg::RST_BRK_SPD, slwf_pkg::RST_BRK_D2,
                     slwf_pkg::RST_REGEN_CAP, slwf_pkg::RST_ALLOC};
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
            flags <= 4'h0;
            flags_o <= 4'h0;
            seq_out_o <= 3'h0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            cfg <= next_cfg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            flags <= next_flags;
            flags_o <= next_flags;
            seq_out_o <= next_seq;
            irq_o <= next_irq;
        end
    end

    // ==========================================================
    // checks
    ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    cur_internal_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && mon_i.torque >= $signed({1'b0, cfg.fwd_tq})) |=> flags.current)
        else $error("current flag missed the forward limit");
    cur_external_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && host_i.ext_limit_on && mon_i.torque >= $signed({1'b0, cfg.fwd_ext}))
        |=> flags.current) else $error("current flag missed the external limit");
    flag_no_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cur_any && !spd_any) |=> (!flags.current && !flags.speed))
        else $error("flag held after its conditions cleared");
    speed_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !torque_mode) |=> !flags.speed) else $error("speed flag outside torque mode");
    warn_torque_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && mon_i.eff_torque > slwf_pkg::WARN_TORQUE_PCT) |=> flags.warn)
        else $error("warning missed on torque overload");
    warn_regen_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cfg.regen_cap != 16'h0000 && mon_i.regen_energy > cfg.regen_cap)
        |=> flags.warn) else $error("warning missed on regen capacity");
    alloc_reset_a: assert property (@(posedge clk_i)
        rst_i |=> (cfg.alloc == slwf_pkg::RST_ALLOC && seq_out_o == 3'h0))
        else $error("allocation not at its reset value");
    brake_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cfg.alloc == slwf_pkg::RST_ALLOC && flags.brake) |=> seq_out_o[0])
        else $error("brake flag not on its default pin");
    brake_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && brk == slwf_pkg::BRK_STOP_WAIT && !mon_i.servo_on && dly_cnt < cfg.brk_d1)
        |=> flags.brake) else $error("brake engaged before the first delay");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (irq_o == |(irq_stat & irq_mask))) else $error("interrupt level wrong");
    irq_set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && next_flags.current && !flags.current) |=> irq_stat.current)
        else $error("current event lost to a status clear");
endmodule

// ===== sim/slwf_host_model.sv
// host controller model: limit designation and option values, one clock late like a real master
module slwf_host_model (
    // clock
    input wire logic clk_i,
    // commands from the test sequence
    input wire logic ext_on_i,
    input wire logic [15:0] opt1_i,
    input wire logic [15:0] opt2_i,
    // towards the block
    output slwf_pkg::slwf_host_t host_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // registered so that the block never sees a change inside the edge that launched it
    always @(posedge clk_i) begin
        host_o <= '{ext_limit_on: ext_on_i, opt_val1: opt1_i, opt_val2: opt2_i};
    end
endmodule

// ===== sim/testbench.sv
// self-checking bench for the servo limit and warning flag block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int kind; logic [31:0] exp; string nm;} slwf_note_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic look = 1'b0;
    logic ce = 1'b1;
    logic ext_on = 1'b0;
    logic ack;
    logic irq;
    logic [2:0] seq;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic [31:0] seen;
    logic [31:0] seed = 32'hf107;
    logic [15:0] opt1 = 16'h20;
    logic [15:0] opt2 = 16'h30;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    slwf_pkg::slwf_mon_t mon = '0;
    slwf_pkg::slwf_host_t host;
    slwf_pkg::slwf_flags_t flags;
    slwf_note_t note;
    slwf_note_t notes[$];

    // ==========================================================
    // partner and block; a short brake tick keeps the delays within a few hundred cycles
    slwf_host_model u_slwf_host_model (.clk_i(clk_i), .ext_on_i(ext_on), .opt1_i(opt1),
        .opt2_i(opt2), .host_o(host));
    slwf_top #(.TICK_CYCLES(4)) u_slwf_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .mon_i(mon), .host_i(host),
        .seq_out_o(seq), .flags_o(flags), .irq_o(irq));

    // ==========================================================
    // clock and hang guard
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            give_verdict();
        end
    end

    // compare the oldest note with the result shown at this edge
    always @(posedge clk_i) begin
        if ((ack && !we) || look) begin
            note = notes.pop_front();
            case (note.kind)
                0: seen = rd;
                1: seen = {28'h0, flags};
                2: seen = {29'h0, seq};
                default: seen = {31'h0, irq};
            endcase
            checks++;
            if (seen !== note.exp) begin
                n_errors++;
                $display("unexpected %s: expected %h seen %h", note.nm, note.exp, seen);
            end
        end
    end

    // ==========================================================
    // tasks
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        notes.push_back('{0, e, nm});
        bus(1'b0, a, 32'h0);
    endtask
    // flags and irq settle one edge after a cause, pins two; the host model adds one more
    task automatic probe(input int k, input logic [31:0] e, input string nm);
        repeat (3) @(posedge clk_i);
        notes.push_back('{k, e, nm});
        look <= 1'b1;
        @(posedge clk_i);
        look <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic step(input logic [15:0] t, s, e, r, input logic [31:0] x, input string nm);
        mon.torque <= t;
        mon.speed <= s;
        mon.eff_torque <= e;
        mon.regen_energy <= r;
        probe(1, x, nm);
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(slwf_pkg::REG_ALLOC, 32'h100, "alloc");
        rdchk(8'h3c, 32'h0, "unmapped");
        probe(2, 32'h0, "seq idle");
        mon.servo_on <= 1'b1;
        step(16'h0, 16'h0, 16'h0, 16'h0, 32'h4, "brake on");
        probe(2, 32'h1, "seq brake");
        done("reset");
        wr(slwf_pkg::REG_CTRL, 32'h2);
        step(16'h15e, 16'h0, 16'h0, 16'h0, 32'h5, "fwd lim");
        step(16'hfea2, 16'h0, 16'h0, 16'h0, 32'h5, "rev lim");
        step(16'h15d, 16'h0, 16'h0, 16'h0, 32'h4, "below lim");
        repeat (4) begin
            seed = xs(seed);
            step({10'h0, seed[5:0]}, 16'h0, 16'h0, 16'h0, 32'h4, "rand low");
        end
        ext_on <= 1'b1;
        step(16'h64, 16'h0, 16'h0, 16'h0, 32'h5, "ext fwd");
        step(16'hff9c, 16'h0, 16'h0, 16'h0, 32'h5, "ext rev");
        ext_on <= 1'b0;
        step(16'h64, 16'h0, 16'h0, 16'h0, 32'h4, "ext off");
        wr(slwf_pkg::REG_CTRL, 32'h12);
        step(16'hffe0, 16'h0, 16'h0, 16'h0, 32'h5, "opt1 rev");
        step(16'h1f, 16'h0, 16'h0, 16'h0, 32'h4, "opt1 below");
        wr(slwf_pkg::REG_CTRL, 32'h32);
        ext_on <= 1'b1;
        step(16'hffd0, 16'h0, 16'h0, 16'h0, 32'h5, "opt2 rev");
        step(16'h20, 16'h0, 16'h0, 16'h0, 32'h5, "opt1 fwd");
        ext_on <= 1'b0;
        step(16'h20, 16'h0, 16'h0, 16'h0, 32'h4, "sel3 off");
        done("current");
        wr(slwf_pkg::REG_CTRL, 32'h2);
        step(16'h0, 16'hd8f0, 16'h0, 16'h0, 32'h6, "spd lim");
        step(16'h0, 16'h270f, 16'h0, 16'h0, 32'h4, "spd below");
        for (int m = 0; m < 4; m++) begin
            if (m != 2) begin
                wr(slwf_pkg::REG_CTRL, m);
                step(16'h0, 16'h2710, 16'h0, 16'h0, 32'h4, "spd mode");
            end
        end
        wr(slwf_pkg::REG_CTRL, 32'h102);
        step(16'h0, 16'h20, 16'h0, 16'h0, 32'h6, "spd opt1");
        done("speed");
        wr(slwf_pkg::REG_CTRL, 32'h0);
        step(16'h0, 16'h0, 16'h73, 16'h0, 32'h4, "eff 115");
        step(16'h0, 16'h0, 16'h74, 16'h0, 32'hc, "eff 116");
        step(16'h0, 16'h0, 16'h0, 16'h1001, 32'hc, "regen int");
        wr(slwf_pkg::REG_REGEN_CAP, 32'h100);
        step(16'h0, 16'h0, 16'h0, 16'h101, 32'hc, "regen ext");
        step(16'h0, 16'h0, 16'h0, 16'h100, 32'h4, "regen ok");
        // with the enable low the flags must keep their last value
        ce <= 1'b0;
        step(16'h15e, 16'h0, 16'h0, 16'h0, 32'h4, "frozen");
        ce <= 1'b1;
        done("warn");
        wr(slwf_pkg::REG_ALLOC, 32'h213);
        step(16'h15e, 16'h0, 16'h0, 16'h0, 32'h5, "alloc cur");
        probe(2, 32'h6, "seq alloc");
        wr(slwf_pkg::REG_IRQ_MASK, 32'h1);
        probe(3, 32'h1, "irq set");
        wr(slwf_pkg::REG_IRQ_STAT, 32'hf);
        probe(3, 32'h0, "irq clear");
        rdchk(slwf_pkg::REG_FLAGS, 32'h5, "flags rd");
        done("alloc irq");
        wr(slwf_pkg::REG_BRK_D1, 32'h2);
        mon.servo_on <= 1'b0;
        step(16'h0, 16'h0, 16'h0, 16'h0, 32'h4, "brake hold");
        repeat (20) @(posedge clk_i);
        step(16'h0, 16'h0, 16'h0, 16'h0, 32'h0, "brake d1");
        mon.servo_on <= 1'b1;
        step(16'h0, 16'h200, 16'h0, 16'h0, 32'h4, "brake run");
        mon.servo_on <= 1'b0;
        step(16'h0, 16'h200, 16'h0, 16'h0, 32'h4, "brake coast");
        step(16'h0, 16'h10, 16'h0, 16'h0, 32'h0, "brake slow");
        mon.servo_on <= 1'b1;
        step(16'h0, 16'h200, 16'h0, 16'h0, 32'h4, "brake rerun");
        mon.servo_on <= 1'b0;
        // fifty units of four clocks, plus margin for the short first unit
        repeat (210) @(posedge clk_i);
        step(16'h0, 16'h200, 16'h0, 16'h0, 32'h0, "brake d2");
        done("brake");
        // a second reset must bring the routing and settings back
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(slwf_pkg::REG_ALLOC, 32'h100, "alloc reset");
        rdchk(slwf_pkg::REG_BRK_D1, 32'h0, "d1 reset");
        done("reset again");
        give_verdict();
    end
endmodule
